// file: design/sfhi_map.vh
`ifndef SFHI_MAP_VH
`define SFHI_MAP_VH
`define SFHI_CLK_MHZ      250
`define SFHI_OPC_WREN     8'h06
`define SFHI_OPC_WRDI     8'h04
`define SFHI_OPC_WRSR     8'h01
`define SFHI_OPC_RDSR1    8'h05
`define SFHI_OPC_RDSR2    8'h35
`define SFHI_OPC_READ     8'h03
`define SFHI_OPC_FREAD    8'h0b
`define SFHI_OPC_DOUT     8'h3b
`define SFHI_OPC_DIO      8'hbb
`define SFHI_OPC_QOUT     8'h6b
`define SFHI_OPC_QIO      8'heb
`define SFHI_OPC_PP       8'h02
`define SFHI_OPC_SE       8'h20
`define SFHI_OPC_BE32     8'h52
`define SFHI_OPC_BE64     8'hd8
`define SFHI_OPC_CE1      8'hc7
`define SFHI_OPC_CE2      8'h60
`define SFHI_OPC_SECP     8'h42
`define SFHI_OPC_SECE     8'h44
`define SFHI_OPC_SUSP     8'h75
`define SFHI_OPC_ENQ      8'h38
`define SFHI_OPC_EXQ      8'hff
`define SFHI_OPC_RST      8'h99
`define SFHI_OPC_PD       8'hb9
`define SFHI_OPC_REL      8'hab
`define SFHI_DUMMY_FAST   5'h08
`define SFHI_DUMMY_DIO    5'h04
`define SFHI_DUMMY_QIO    5'h06
`define SFHI_LANE1        3'h1
`define SFHI_LANE2        3'h2
`define SFHI_LANE4        3'h4
`define SFHI_SR1_BUSY     0
`define SFHI_SR1_WEL      1
`define SFHI_SR1_PROT     7
`define SFHI_SR2_LOCK     0
`define SFHI_SR2_QE       1
`define SFHI_PIN_IO0      0
`define SFHI_PIN_IO1      1
`define SFHI_PIN_WP       4
`define SFHI_PIN_HOLD     5
`define SFHI_PIN_CSN      6
`define SFHI_PIN_SCLK     7
`define SFHI_PIN_INIT     8'h70
`endif

// file: design/sfhi_sync.v
`timescale 1ns/100ps
module sfhi_sync #(
  parameter       W    = 8,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  integer     i;

  // a bit moves only once stages two and three agree, which rejects glitches
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      dout   <= INIT;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // sfhi_sync

// file: design/sfhi_core.v
`timescale 1ns/100ps
`include "sfhi_map.vh"
module sfhi_core #(
  parameter        PUW_TIME_US = 10,
  parameter        PUW_CYCLES  = PUW_TIME_US * `SFHI_CLK_MHZ,
  parameter [0:0]  INIT_QE     = 1'b0,
  parameter [0:0]  INIT_PROT   = 1'b0
) (
  input  wire        CORE_CLK,
  input  wire        RSTN,
  input  wire        SCLK,
  input  wire        CS_N,
  input  wire [3:0]  IO_IN,
  output reg  [3:0]  IO_OUT,
  output reg  [3:0]  IO_OE,
  input  wire [7:0]  RD_DATA,
  output reg  [23:0] RD_ADDR,
  output reg         RD_TAKEN,
  output reg  [7:0]  WR_DATA,
  output reg         WR_VALID,
  output reg         OP_REQ,
  output reg  [7:0]  OP_CODE,
  output reg  [23:0] OP_ADDR,
  input  wire        OP_DONE,
  output wire        BUSY,
  output wire        WRITE_ENABLE_LATCH,
  output wire        QUAD_ENABLE_BIT,
  output wire        STATUS_PROTECT_BIT,
  output wire        STATUS_LOCK_BIT,
  output wire        FOUR_WIRE_COMMAND_MODE,
  output wire        POWER_DOWN,
  output wire        PAUSED,
  output wire        WRITE_READY
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_OPC  = 7'h02;
  localparam [6:0] ST_ADDR = 7'h04;
  localparam [6:0] ST_DUMY = 7'h08;
  localparam [6:0] ST_DIN  = 7'h10;
  localparam [6:0] ST_DOUT = 7'h20;
  localparam [6:0] ST_WAIT = 7'h40;

  wire [7:0] pin_s;
  sfhi_sync #(.W(8), .INIT(`SFHI_PIN_INIT)) u_sync (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .din   ({SCLK, CS_N, IO_IN, 2'b00}),
    .dout  (pin_s)
  );
  wire [3:0] io_s   = pin_s[5:2];
  wire       csn_s  = pin_s[`SFHI_PIN_CSN];
  wire       sclk_s = pin_s[`SFHI_PIN_SCLK];

  reg        sclk_d_reg;
  reg        csn_d_reg;
  reg [6:0]  st_reg;
  reg [6:0]  after_reg;
  reg [23:0] sh_reg;
  reg [4:0]  cnt_reg;
  reg [4:0]  dummy_reg;
  reg [2:0]  in_ln_reg;
  reg [2:0]  out_ln_reg;
  reg [7:0]  opc_reg;
  reg [7:0]  out_reg;
  reg [4:0]  ocnt_reg;
  reg        oact_reg;
  reg [1:0]  nbyte_reg;
  reg [7:0]  wsr1_reg;
  reg [7:0]  wsr2_reg;
  reg        pause_reg;
  reg        busy_reg;
  reg        wel_reg;
  reg        qe_reg;
  reg        prot_reg;
  reg        lock_reg;
  reg        qpi_reg;
  reg        pd_reg;
  reg        puw_done_reg;
  reg [15:0] puw_cnt_reg;

  wire       sclk_rise = sclk_s & ~sclk_d_reg;
  wire       sclk_fall = ~sclk_s & sclk_d_reg;
  wire       cs_fall   = ~csn_s & csn_d_reg;
  wire       cs_rise   = csn_s & ~csn_d_reg;
  wire       hold_on   = ~io_s[3] & ~qe_reg & ~csn_s;
  wire       rise_ok   = sclk_rise & ~csn_s & ~pause_reg;
  wire       fall_ok   = sclk_fall & ~csn_s & ~pause_reg;
  wire [7:0] sr1 = {prot_reg, 5'h00, wel_reg, busy_reg};
  wire [7:0] sr2 = {6'h00, qe_reg, lock_reg};

  assign BUSY                   = busy_reg;
  assign WRITE_ENABLE_LATCH     = wel_reg;
  assign QUAD_ENABLE_BIT        = qe_reg;
  assign STATUS_PROTECT_BIT     = prot_reg;
  assign STATUS_LOCK_BIT        = lock_reg;
  assign FOUR_WIRE_COMMAND_MODE = qpi_reg;
  assign POWER_DOWN             = pd_reg;
  assign PAUSED                 = pause_reg;
  assign WRITE_READY            = puw_done_reg;

  function [4:0] cpb;
    input [2:0] ln;
    begin
      cpb = (ln == `SFHI_LANE4) ? 5'h02 : (ln == `SFHI_LANE2) ? 5'h04 : 5'h08;
    end
  endfunction

  function [23:0] shin;
    input [23:0] s;
    input [3:0]  io;
    input [2:0]  ln;
    begin
      case (ln)
        `SFHI_LANE4: shin = {s[19:0], io};
        `SFHI_LANE2: shin = {s[21:0], io[1:0]};
        default:     shin = {s[22:0], io[0]};
      endcase
    end
  endfunction

  wire [23:0] sh_new = shin(sh_reg, io_s, in_ln_reg);
  wire [7:0]  b      = sh_new[7:0];
  wire [4:0]  cnt_p1 = cnt_reg + 5'h01;
  wire [2:0]  cmd_ln = qpi_reg ? `SFHI_LANE4 : `SFHI_LANE1;

  // decode of a completed opcode
  reg [6:0] d_st;
  reg [6:0] d_after;
  reg [2:0] d_aln;
  reg [2:0] d_oln;
  reg [4:0] d_dum;
  reg       d_wr;
  reg       d_ok;
  always @* begin
    d_st    = ST_IDLE;
    d_after = ST_WAIT;
    d_aln   = cmd_ln;
    d_oln   = cmd_ln;
    d_dum   = 5'h00;
    d_wr    = 1'b0;
    d_ok    = 1'b1;
    case (b)
      `SFHI_OPC_WREN, `SFHI_OPC_CE1, `SFHI_OPC_CE2: begin
        d_st = ST_WAIT;
        d_wr = 1'b1;
      end
      `SFHI_OPC_WRDI, `SFHI_OPC_EXQ, `SFHI_OPC_RST, `SFHI_OPC_PD,
      `SFHI_OPC_REL, `SFHI_OPC_SUSP: d_st = ST_WAIT;
      `SFHI_OPC_ENQ: begin
        d_st = ST_WAIT;
        d_ok = qe_reg;
      end
      `SFHI_OPC_PP, `SFHI_OPC_SECP: begin
        d_st    = ST_ADDR;
        d_after = ST_DIN;
        d_wr    = 1'b1;
      end
      `SFHI_OPC_SE, `SFHI_OPC_BE32, `SFHI_OPC_BE64, `SFHI_OPC_SECE: begin
        d_st = ST_ADDR;
        d_wr = 1'b1;
      end
      `SFHI_OPC_WRSR: begin
        d_st = ST_DIN;
        d_wr = 1'b1;
      end
      `SFHI_OPC_RDSR1, `SFHI_OPC_RDSR2: d_st = ST_DOUT;
      `SFHI_OPC_READ: begin
        d_st    = ST_ADDR;
        d_after = ST_DOUT;
      end
      `SFHI_OPC_FREAD: begin
        d_st    = ST_ADDR;
        d_after = ST_DOUT;
        d_dum   = `SFHI_DUMMY_FAST;
      end
      `SFHI_OPC_DOUT, `SFHI_OPC_DIO: begin
        d_st    = ST_ADDR;
        d_after = ST_DOUT;
        d_oln   = qpi_reg ? `SFHI_LANE4 : `SFHI_LANE2;
        d_aln   = (qpi_reg || b == `SFHI_OPC_DIO) ? d_oln : `SFHI_LANE1;
        d_dum   = (b == `SFHI_OPC_DIO) ? `SFHI_DUMMY_DIO : `SFHI_DUMMY_FAST;
      end
      `SFHI_OPC_QOUT, `SFHI_OPC_QIO: begin
        d_st    = ST_ADDR;
        d_after = ST_DOUT;
        d_oln   = `SFHI_LANE4;
        d_aln   = (qpi_reg || b == `SFHI_OPC_QIO) ? `SFHI_LANE4 : `SFHI_LANE1;
        d_dum   = (b == `SFHI_OPC_QIO) ? `SFHI_DUMMY_QIO : `SFHI_DUMMY_FAST;
        d_ok    = qe_reg;
      end
      default: d_ok = 1'b0;
    endcase
    if (pd_reg && b != `SFHI_OPC_REL) begin
      d_ok = 1'b0;
    end
    if (busy_reg && b != `SFHI_OPC_RDSR1 && b != `SFHI_OPC_RDSR2 &&
        b != `SFHI_OPC_SUSP) begin
      d_ok = 1'b0;
    end
    if (d_wr && (!puw_done_reg || (b != `SFHI_OPC_WREN && !wel_reg))) begin
      d_ok = 1'b0;
    end
    if (!d_ok) begin
      d_st = ST_IDLE;
    end
  end

  // status write permission; pin ignored once it is a data lane
  wire wp_low = ~io_s[2] & ~qe_reg;
  wire wsr_ok = wel_reg & ~lock_reg & ~(prot_reg & wp_low);
  wire commit = cs_rise && ((st_reg == ST_WAIT) ||
                (st_reg == ST_DIN && cnt_reg == 5'h00 && nbyte_reg != 2'h0));

  reg       req_next;
  reg       wel_set;
  reg       wel_clr;
  always @* begin
    req_next = 1'b0;
    wel_set  = 1'b0;
    wel_clr  = OP_DONE;
    if (commit) begin
      case (opc_reg)
        `SFHI_OPC_WREN: wel_set = 1'b1;
        `SFHI_OPC_WRDI: wel_clr = 1'b1;
        `SFHI_OPC_WRSR: req_next = wsr_ok;
        `SFHI_OPC_ENQ, `SFHI_OPC_EXQ, `SFHI_OPC_RST,
        `SFHI_OPC_PD, `SFHI_OPC_REL: req_next = 1'b0;
        default: req_next = 1'b1;
      endcase
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      puw_cnt_reg  <= 16'h0000;
      puw_done_reg <= 1'b0;
    end else if (!puw_done_reg) begin
      puw_cnt_reg  <= puw_cnt_reg + 16'h0001;
      puw_done_reg <= (puw_cnt_reg >= PUW_CYCLES[15:0] - 16'h0001);
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sclk_d_reg <= 1'b0;
      csn_d_reg  <= 1'b1;
      st_reg     <= ST_IDLE;
      after_reg  <= ST_WAIT;
      sh_reg     <= 24'h000000;
      cnt_reg    <= 5'h00;
      dummy_reg  <= 5'h00;
      in_ln_reg  <= `SFHI_LANE1;
      out_ln_reg <= `SFHI_LANE1;
      opc_reg    <= 8'h00;
      out_reg    <= 8'h00;
      ocnt_reg   <= 5'h00;
      oact_reg   <= 1'b0;
      nbyte_reg  <= 2'h0;
      wsr1_reg   <= 8'h00;
      wsr2_reg   <= 8'h00;
      pause_reg  <= 1'b0;
      busy_reg   <= 1'b0;
      wel_reg    <= 1'b0;
      qe_reg     <= INIT_QE;
      prot_reg   <= INIT_PROT;
      lock_reg   <= 1'b0;
      qpi_reg    <= 1'b0;
      pd_reg     <= 1'b0;
      RD_ADDR    <= 24'h000000;
      RD_TAKEN   <= 1'b0;
      WR_DATA    <= 8'h00;
      WR_VALID   <= 1'b0;
      OP_REQ     <= 1'b0;
      OP_CODE    <= 8'h00;
      OP_ADDR    <= 24'h000000;
    end else begin
      sclk_d_reg <= sclk_s;
      csn_d_reg  <= csn_s;
      RD_TAKEN   <= 1'b0;
      WR_VALID   <= 1'b0;
      OP_REQ     <= req_next;
      if (!hold_on && (csn_s || qe_reg)) begin
        pause_reg <= 1'b0;
      end else if (hold_on != pause_reg && (!sclk_s || sclk_fall)) begin
        pause_reg <= hold_on;
      end
      // busy flag; a new request wins over completion
      if (req_next) begin
        busy_reg <= 1'b1;
      end else if (OP_DONE) begin
        busy_reg <= 1'b0;
      end
      // latch cleared on completion, set wins
      if (wel_set) begin
        wel_reg <= 1'b1;
      end else if (wel_clr) begin
        wel_reg <= 1'b0;
      end
      if (commit) begin
        OP_CODE <= opc_reg;
        // data bytes have displaced the address in sh_reg by now
        OP_ADDR <= RD_ADDR;
        case (opc_reg)
          `SFHI_OPC_ENQ: qpi_reg <= 1'b1;
          `SFHI_OPC_EXQ, `SFHI_OPC_RST: qpi_reg <= 1'b0;
          `SFHI_OPC_PD:  pd_reg <= 1'b1;
          `SFHI_OPC_REL: pd_reg <= 1'b0;
          `SFHI_OPC_WRSR: begin
            if (wsr_ok) begin
              prot_reg <= wsr1_reg[`SFHI_SR1_PROT];
              if (nbyte_reg == 2'h2) begin
                lock_reg <= wsr2_reg[`SFHI_SR2_LOCK];
                qe_reg   <= wsr2_reg[`SFHI_SR2_QE] | qpi_reg;
              end
            end
          end
          default: pd_reg <= pd_reg;
        endcase
      end
      if (csn_s) begin
        st_reg   <= ST_IDLE;
        oact_reg <= 1'b0;
      end else if (cs_fall) begin
        st_reg    <= ST_OPC;
        cnt_reg   <= 5'h00;
        in_ln_reg <= cmd_ln;
        nbyte_reg <= 2'h0;
        oact_reg  <= 1'b0;
        ocnt_reg  <= 5'h00;
      end else if (rise_ok) begin
        sh_reg  <= sh_new;
        cnt_reg <= cnt_p1;
        case (st_reg)
          ST_OPC: begin
            if (cnt_p1 == cpb(in_ln_reg)) begin
              opc_reg    <= b;
              st_reg     <= d_st;
              after_reg  <= d_after;
              in_ln_reg  <= (d_st == ST_DIN) ? cmd_ln : d_aln;
              out_ln_reg <= d_oln;
              dummy_reg  <= d_dum;
              cnt_reg    <= 5'h00;
            end
          end
          ST_ADDR: begin
            if (cnt_p1 == 5'h03 * cpb(in_ln_reg)) begin
              cnt_reg   <= 5'h00;
              RD_ADDR   <= sh_new;
              in_ln_reg <= cmd_ln;
              if (after_reg == ST_DOUT && dummy_reg != 5'h00) begin
                st_reg <= ST_DUMY;
              end else begin
                st_reg <= after_reg;
              end
            end
          end
          ST_DUMY: begin
            if (cnt_p1 == dummy_reg) begin
              st_reg  <= ST_DOUT;
              cnt_reg <= 5'h00;
            end
          end
          ST_DIN: begin
            if (cnt_p1 == cpb(in_ln_reg)) begin
              cnt_reg  <= 5'h00;
              WR_DATA  <= b;
              WR_VALID <= (opc_reg != `SFHI_OPC_WRSR);
              if (nbyte_reg == 2'h0) begin
                wsr1_reg <= b;
              end else if (nbyte_reg == 2'h1) begin
                wsr2_reg <= b;
              end
              if (nbyte_reg != 2'h2) begin
                nbyte_reg <= nbyte_reg + 2'h1;
              end
            end
          end
          ST_DOUT: cnt_reg <= 5'h00;
          ST_WAIT: st_reg <= ST_IDLE;
          default: cnt_reg <= 5'h00;
        endcase
      end else if (fall_ok && st_reg == ST_DOUT) begin
        oact_reg <= 1'b1;
        ocnt_reg <= (ocnt_reg + 5'h01 == cpb(out_ln_reg)) ? 5'h00 : ocnt_reg + 5'h01;
        if (ocnt_reg != 5'h00) begin
          out_reg <= out_reg << out_ln_reg;
        end else if (opc_reg == `SFHI_OPC_RDSR1) begin
          out_reg <= sr1;
        end else if (opc_reg == `SFHI_OPC_RDSR2) begin
          out_reg <= sr2;
        end else begin
          out_reg  <= RD_DATA;
          RD_TAKEN <= 1'b1;
          RD_ADDR  <= RD_ADDR + 24'h000001;
        end
      end
    end
  end

  // outputs float while paused or deselected
  always @* begin
    IO_OUT = 4'h0;
    IO_OE  = 4'h0;
    case (out_ln_reg)
      `SFHI_LANE4: IO_OUT = out_reg[7:4];
      `SFHI_LANE2: IO_OUT = {2'b00, out_reg[7:6]};
      default:     IO_OUT = {2'b00, out_reg[7], 1'b0};
    endcase
    if (oact_reg && st_reg == ST_DOUT && !pause_reg && !csn_s) begin
      case (out_ln_reg)
        `SFHI_LANE4: IO_OE = 4'hf;
        `SFHI_LANE2: IO_OE = 4'h3;
        default:     IO_OE = 4'h2;
      endcase
    end
  end
endmodule // sfhi_core

// file: bench/sfhi_core_asserts.sv
`timescale 1ns/100ps
`include "sfhi_map.vh"
module sfhi_core_asserts #(
  parameter PUW_CYCLES = 8
) (
  input wire       CORE_CLK,
  input wire       RSTN,
  input wire [3:0] IO_OE,
  input wire       OP_REQ,
  input wire [7:0] OP_CODE,
  input wire       OP_DONE,
  input wire       BUSY,
  input wire       WRITE_ENABLE_LATCH,
  input wire       QUAD_ENABLE_BIT,
  input wire       FOUR_WIRE_COMMAND_MODE,
  input wire       POWER_DOWN,
  input wire       PAUSED,
  input wire       WRITE_READY
);
  reg [15:0] puw_cnt_reg;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  // cycles spent before writes are allowed
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN)
      puw_cnt_reg <= 16'h0000;
    else if (!WRITE_READY)
      puw_cnt_reg <= puw_cnt_reg + 16'h0001;
  end
  a_req_sets_busy: assert property (OP_REQ |-> ##[0:1] BUSY)
    else $error("busy missing after request");
  a_done_clears: assert property (OP_DONE && !OP_REQ |=> !BUSY && !WRITE_ENABLE_LATCH)
    else $error("done left busy or latch set");
  a_req_has_latch: assert property (OP_REQ && OP_CODE != `SFHI_OPC_SUSP
    |-> WRITE_ENABLE_LATCH)
    else $error("request without latch");
  a_req_after_puw: assert property (OP_REQ |-> WRITE_READY)
    else $error("request before write delay");
  a_busy_blocks: assert property (OP_REQ && $past(BUSY) |-> OP_CODE == `SFHI_OPC_SUSP)
    else $error("request taken while busy");
  a_pause_float: assert property (PAUSED && $past(PAUSED) |-> IO_OE == 4'h0)
    else $error("output driven in pause");
  a_pause_serial: assert property (PAUSED |-> !QUAD_ENABLE_BIT)
    else $error("pause with quad enable");
  a_four_wire_qe: assert property (FOUR_WIRE_COMMAND_MODE |-> QUAD_ENABLE_BIT)
    else $error("four-wire mode without quad enable");
  a_lane_sets: assert property (IO_OE != 4'h0 |-> IO_OE == 4'h2 || IO_OE == 4'h3
    || (IO_OE == 4'hf && QUAD_ENABLE_BIT))
    else $error("bad output lane set");
  a_latch_rise: assert property ($rose(WRITE_ENABLE_LATCH)
    |-> WRITE_READY && !BUSY && !POWER_DOWN)
    else $error("latch set while refused");
  a_puw_count: assert property ($rose(WRITE_READY)
    |-> puw_cnt_reg >= PUW_CYCLES - 1 && puw_cnt_reg <= PUW_CYCLES + 1)
    else $error("write delay length wrong");
  cover property (OP_REQ && OP_CODE == `SFHI_OPC_PP);
  cover property (PAUSED);
  cover property (FOUR_WIRE_COMMAND_MODE);
  cover property (IO_OE == 4'hf);
endmodule // sfhi_core_asserts

// file: bench/sfhi_host.sv
`timescale 1ns/100ps
module sfhi_host (
  input  wire       clk,
  input  wire [3:0] dev_out,
  input  wire [3:0] dev_oe,
  output reg        sclk,
  output reg        cs_n,
  output wire [3:0] io
);
  reg [3:0] drv;
  reg [3:0] hoe;
  // released data lines read inverted; protect and pause lines have pull-ups
  assign io = (dev_oe & dev_out) | (~dev_oe & ((hoe & drv) | (~hoe & {2'b11, ~drv[1:0]})));
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv  = 4'hf;
    hoe  = 4'hf;
  end
  // six core cycles per half so the synchroniser sees every level
  task half;
    begin
      repeat (6) @(posedge clk);
      #1;
    end
  endtask
  task sel;
    begin
      cs_n = 1'b0;
      half;
    end
  endtask
  task desel;
    begin
      half;
      cs_n = 1'b1;
      hoe  = 4'hf;
      half;
      half;
    end
  endtask
  task tx(input [31:0] v, input integer n, input integer ln);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        if (ln == 4)
          drv = v[31:28];
        else if (ln == 2)
          drv[1:0] = v[31:30];
        else
          drv[0] = v[31];
        v = v << ln;
        half;
        sclk = 1'b1;
        half;
        sclk = 1'b0;
      end
    end
  endtask
  task rx(output [7:0] b, output [3:0] oe);
    integer k;
    begin
      hoe = 4'h0;
      for (k = 0; k < 8; k = k + 1) begin
        half;
        if (k == 0)
          oe = dev_oe;
        b = {b[6:0], io[1]};
        sclk = 1'b1;
        half;
        sclk = 1'b0;
      end
    end
  endtask
  task pin(input [1:0] v);
    drv[3:2] = v;
  endtask
endmodule // sfhi_host

// file: bench/sfhi_core_tb.sv
`timescale 1ns/100ps
module sfhi_core_tb;
  reg         clk;
  reg         rst_n;
  reg         op_done;
  reg  [7:0]  wr_last;
  reg  [7:0]  b;
  reg  [3:0]  oe;
  integer     n_errors;
  integer     n_compared;
  integer     n_req = 0;
  integer     i;
  wire        sclk;
  wire        cs_n;
  wire [3:0]  io_in;
  wire [3:0]  io_out;
  wire [3:0]  io_oe;
  wire [23:0] rd_addr;
  wire [7:0]  rd_data = rd_addr[7:0] ^ 8'h5c;
  sfhi_host host (.clk(clk), .dev_out(io_out), .dev_oe(io_oe), .sclk(sclk), .cs_n(cs_n),
    .io(io_in));
  sfhi_core #(.PUW_CYCLES(400)) dut (.CORE_CLK(clk), .RSTN(rst_n), .SCLK(sclk), .CS_N(cs_n),
    .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe), .RD_DATA(rd_data), .RD_ADDR(rd_addr),
    .RD_TAKEN(), .WR_DATA(), .WR_VALID(), .OP_REQ(), .OP_CODE(), .OP_ADDR(),
    .OP_DONE(op_done), .BUSY(), .WRITE_ENABLE_LATCH(), .QUAD_ENABLE_BIT(),
    .STATUS_PROTECT_BIT(), .STATUS_LOCK_BIT(), .FOUR_WIRE_COMMAND_MODE(), .POWER_DOWN(),
    .PAUSED(), .WRITE_READY());
  always @(posedge clk) begin
    if (dut.OP_REQ === 1'b1)
      n_req <= n_req + 1;
    if (dut.WR_VALID === 1'b1)
      wr_last <= dut.WR_DATA;
  end
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cmd(input [7:0] op, input [31:0] d, input integer n);
    begin
      host.sel;
      host.tx({op, 24'h000000}, 8, 1);
      if (n > 0)
        host.tx(d, n, 1);
      host.desel;
    end
  endtask
  task qcmd(input [7:0] op);
    begin
      host.sel;
      host.tx({op, 24'h000000}, 2, 4);
      host.desel;
    end
  endtask
  task rd(input [7:0] op, input integer n);
    begin
      host.sel;
      host.tx({op, 24'h000000}, 8, 1);
      if (n > 0)
        host.tx(32'h00000000, n, 1);
      host.rx(b, oe);
      host.desel;
    end
  endtask
  task done;
    begin
      op_done = 1'b1;
      cyc(1);
      op_done = 1'b0;
      cyc(2);
    end
  endtask
  task results;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors = n_errors + 1;
    results;
  end
  initial begin
    rst_n = 1'b0;
    op_done = 1'b0;
    n_errors = 0;
    n_compared = 0;
    cyc(10);
    rst_n = 1'b1;
    cyc(8);
    chk(dut.WRITE_ENABLE_LATCH, 0);
    chk(dut.FOUR_WIRE_COMMAND_MODE, 0);
    chk(dut.WRITE_READY, 0);
    cmd(8'h06, 0, 0);
    chk(dut.WRITE_ENABLE_LATCH, 0);
    cyc(400);
    chk(dut.WRITE_READY, 1);
    cmd(8'h38, 0, 0);
    chk(dut.FOUR_WIRE_COMMAND_MODE, 0);
    host.sel;
    host.tx(32'h00000000, 4, 1);
    host.desel;
    chk(dut.WRITE_ENABLE_LATCH, 0);
    cmd(8'h06, 0, 4);
    chk(dut.WRITE_ENABLE_LATCH, 0);
    host.sel;
    host.tx(32'h00000000, 4, 1);
    host.pin(2'b01);
    cyc(10);
    chk(dut.PAUSED, 1);
    chk(io_oe, 4'h0);
    host.tx(32'hffffffff, 3, 1);
    host.pin(2'b11);
    cyc(10);
    chk(dut.PAUSED, 0);
    host.tx(32'h60000000, 4, 1);
    host.desel;
    chk(dut.WRITE_ENABLE_LATCH, 1);
    cmd(8'h04, 0, 0);
    chk(dut.WRITE_ENABLE_LATCH, 0);
    cmd(8'h02, {24'h000010, 8'ha5}, 32);
    chk(n_req, 0);
    cmd(8'hb9, 0, 0);
    chk(dut.POWER_DOWN, 1);
    cmd(8'h06, 0, 0);
    chk(dut.WRITE_ENABLE_LATCH, 0);
    cmd(8'hab, 0, 0);
    chk(dut.POWER_DOWN, 0);
    cmd(8'h06, 0, 0);
    cmd(8'h02, {24'h000010, 8'ha5}, 32);
    chk(wr_last, 8'ha5);
    chk(n_req, 1);
    chk(dut.OP_CODE, 8'h02);
    chk(dut.OP_ADDR, 24'h000010);
    chk(dut.BUSY, 1);
    cmd(8'h20, 32'h00000000, 24);
    chk(n_req, 1);
    rd(8'h05, 0);
    chk(b, 8'h03);
    cmd(8'h75, 0, 0);
    chk(dut.OP_CODE, 8'h75);
    done;
    chk(dut.BUSY, 0);
    chk(dut.WRITE_ENABLE_LATCH, 0);
    cmd(8'h06, 0, 0);
    cmd(8'h01, 32'h80000000, 8);
    chk(dut.STATUS_PROTECT_BIT, 1);
    done;
    host.pin(2'b10);
    cmd(8'h06, 0, 0);
    cmd(8'h01, 32'h00000000, 8);
    chk(dut.STATUS_PROTECT_BIT, 1);
    chk(n_req, 3);
    host.pin(2'b11);
    cmd(8'h06, 0, 0);
    cmd(8'h01, 32'h80020000, 16);
    chk(dut.QUAD_ENABLE_BIT, 1);
    done;
    rd(8'h35, 0);
    chk(b, 8'h02);
    cmd(8'h38, 0, 0);
    chk(dut.FOUR_WIRE_COMMAND_MODE, 1);
    qcmd(8'hff);
    chk(dut.FOUR_WIRE_COMMAND_MODE, 0);
    cmd(8'h38, 0, 0);
    qcmd(8'h99);
    chk(dut.FOUR_WIRE_COMMAND_MODE, 0);
    for (i = 0; i < 5; i = i + 1) begin
      rd(i == 0 ? 8'h03 : i == 1 ? 8'h3b : i == 2 ? 8'h6b : i == 3 ? 8'hbb : 8'heb,
        i == 0 ? 24 : i == 3 ? 16 : i == 4 ? 12 : 32);
      chk(oe, i == 0 ? 4'h2 : (i == 1 || i == 3) ? 4'h3 : 4'hf);
      if (i == 0)
        chk(b, 8'h5c);
    end
    cmd(8'h06, 0, 0);
    cmd(8'h01, 32'h80030000, 16);
    chk(dut.STATUS_LOCK_BIT, 1);
    done;
    cmd(8'h06, 0, 0);
    cmd(8'h01, 32'h00000000, 8);
    chk(dut.STATUS_PROTECT_BIT, 1);
    results;
  end
endmodule // sfhi_core_tb
bind sfhi_core sfhi_core_asserts #(.PUW_CYCLES(PUW_CYCLES)) u_chk (.CORE_CLK(CORE_CLK),
  .RSTN(RSTN), .IO_OE(IO_OE), .OP_REQ(OP_REQ), .OP_CODE(OP_CODE), .OP_DONE(OP_DONE),
  .BUSY(BUSY), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .QUAD_ENABLE_BIT(QUAD_ENABLE_BIT),
  .FOUR_WIRE_COMMAND_MODE(FOUR_WIRE_COMMAND_MODE), .POWER_DOWN(POWER_DOWN),
  .PAUSED(PAUSED), .WRITE_READY(WRITE_READY));
